// file: hw/lic_pkg.sv
// constants and types shared by the local interrupt unit
package lic_pkg;
    // ------------------------------------------------------------
    // register window
    // ------------------------------------------------------------
    localparam int unsigned PAGE_AW     = 12;
    localparam int unsigned MSR_AW      = 8;
    localparam int unsigned REG_AW      = 6;
    localparam int unsigned NREGS       = 64;
    localparam int unsigned DW          = 32;
    localparam int unsigned PAGE_IDX_LO = 4;
    localparam logic [5:0] R_ID   = 6'h02;
    localparam logic [5:0] R_TPR  = 6'h08;
    localparam logic [5:0] R_EOI  = 6'h0b;
    localparam logic [5:0] R_LDR  = 6'h0d;
    localparam logic [5:0] R_CTL  = 6'h0f;
    localparam logic [5:0] R_ISR  = 6'h10;
    localparam logic [5:0] R_POL  = 6'h3f;
    // ------------------------------------------------------------
    // destination fields
    // ------------------------------------------------------------
    localparam int unsigned COMPAT_IDW  = 8;
    localparam int unsigned PHYS_KEEP   = 16;
    localparam int unsigned HALF_W      = 16;
    localparam int unsigned KEEP_W      = 8;
    localparam int unsigned NCORES      = 4;
    localparam logic [31:0] BCAST_EXT   = 32'hffff_ffff;
    localparam logic [7:0]  BCAST_CMP   = 8'hff;
    localparam logic [31:0] ZERO32      = 32'h0000_0000;
    typedef enum logic [1:0] {
        LIC_CS_C0   = 2'h0,
        LIC_CS_C1   = 2'h1,
        LIC_CS_DEEP = 2'h3
    } lic_cstate_t;
    typedef enum logic [1:0] {
        LIC_ST_IDLE = 2'h0,
        LIC_ST_PICK = 2'h1,
        LIC_ST_SEND = 2'h3
    } lic_state_t;
endpackage : lic_pkg

// file: hw/lic_regmem.sv
// small register memory with registered read data
module lic_regmem
    import lic_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              we,
    input  wire logic [REG_AW-1:0] waddr,
    input  wire logic [DW-1:0]     wdata,
    input  wire logic [REG_AW-1:0] raddr,
    output logic      [DW-1:0]     rdata_q
);
    logic [DW-1:0] mem_q [NREGS];
    logic [DW-1:0] rdata_d;

    always_comb
    begin
        rdata_d = mem_q[raddr];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NREGS; i++)
                mem_q[i] <= ZERO32;
            rdata_q <= ZERO32;
        end
        else
        begin
            if (we)
                mem_q[waddr] <= wdata;
            rdata_q <= rdata_d;
        end
    end
endmodule : lic_regmem

// file: hw/lic_route.sv
// idle-state based target chooser
module lic_route
    import lic_pkg::*;
(
    input  wire logic [NCORES-1:0]   cand,
    input  wire logic [2*NCORES-1:0] cstate,
    input  wire logic                perf,
    output logic                     found,
    output logic [1:0]               pick
);
    always_comb
    begin
        logic [NCORES-1:0] pref;
        pref  = '0;
        found = 1'b0;
        pick  = 2'd0;
        for (int i = 0; i < NCORES; i++)
            pref[i] = cand[i] && (cstate[2*i +: 2] == (perf ? LIC_CS_C1 : LIC_CS_C0));
        // prefer policy class, fall back to any candidate
        for (int i = NCORES - 1; i >= 0; i--)
            if (cand[i] && !(|pref))
            begin
                found = 1'b1;
                pick  = 2'(i);
            end
        for (int i = NCORES - 1; i >= 0; i--)
            if (pref[i])
            begin
                found = 1'b1;
                pick  = 2'(i);
            end
    end
endmodule : lic_route

// file: hw/lic_top.sv
// local interrupt unit: page/msr access, id widening, routing
module lic_top
    import lic_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                page_req,
    input  wire logic                page_wr,
    input  wire logic [PAGE_AW-1:0]  page_addr,
    input  wire logic [DW-1:0]       page_wdata,
    output logic                     page_ack_q,
    output logic                     page_err_q,
    output logic [DW-1:0]            page_rdata_q,
    input  wire logic                msr_req,
    input  wire logic                msr_wr,
    input  wire logic [MSR_AW-1:0]   msr_addr,
    input  wire logic [DW-1:0]       msr_wdata,
    output logic                     msr_ack_q,
    output logic                     msr_err_q,
    output logic [DW-1:0]            msr_rdata_q,
    input  wire logic                ext_mode_en,
    input  wire logic                irq_req,
    input  wire logic                irq_logical,
    input  wire logic                irq_redir,
    input  wire logic [31:0]         irq_dest,
    input  wire logic [7:0]          irq_vector,
    input  wire logic [2*NCORES-1:0] core_cstate,
    input  wire logic [NCORES*32-1:0] core_ids,
    output logic                     irq_busy_q,
    output logic                     deliver_q,
    output logic [NCORES-1:0]        deliver_mask_q,
    output logic [7:0]               deliver_vector_q
);
    // ------------------------------------------------------------
    // mode and register access
    // ------------------------------------------------------------
    logic ext_q, ext_d;
    logic pend_q, pend_d, pmsr_q, pmsr_d;
    logic page_ack_d, page_err_d, msr_ack_d, msr_err_d;
    logic          mem_we;
    logic [REG_AW-1:0] mem_waddr, mem_raddr;
    logic [DW-1:0] mem_wdata, mem_rdata;
    logic [DW-1:0] ldr_q, ldr_d, pol_q, pol_d;
    logic          page_ok;
    logic [REG_AW-1:0] idx_q, idx_d;

    // extended mode only entered by software; leaving needs reset
    assign page_ok = page_req && !ext_q;

    always_comb
    begin
        ext_d      = ext_q | ext_mode_en;
        page_ack_d = 1'b0;
        page_err_d = 1'b0;
        msr_ack_d  = 1'b0;
        msr_err_d  = 1'b0;
        mem_we     = 1'b0;
        mem_waddr  = '0;
        mem_wdata  = ZERO32;
        // index held so read data still stands when the ack rises
        mem_raddr  = idx_q;
        idx_d      = idx_q;
        pend_d     = 1'b0;
        pmsr_d     = pmsr_q;
        ldr_d      = ldr_q;
        pol_d      = pol_q;
        if (page_req && ext_q)
        begin
            page_ack_d = 1'b1;
            page_err_d = 1'b1;
        end
        else if (page_ok)
        begin
            // 16-byte spaced registers in one 4 KB page
            mem_raddr = page_addr[PAGE_IDX_LO +: REG_AW];
            mem_we    = page_wr;
            mem_waddr = mem_raddr;
            mem_wdata = page_wdata;
            pend_d    = 1'b1;
            pmsr_d    = 1'b0;
            idx_d     = mem_raddr;
        end
        else if (msr_req && ext_q)
        begin
            mem_raddr = msr_addr[REG_AW-1:0];
            mem_we    = msr_wr;
            mem_waddr = mem_raddr;
            mem_wdata = msr_wdata;
            pend_d    = 1'b1;
            pmsr_d    = 1'b1;
            idx_d     = mem_raddr;
        end
        else if (msr_req)
        begin
            msr_ack_d = 1'b1;
            msr_err_d = 1'b1;
        end
        if (pend_q)
        begin
            // a refusal in this cycle must not be swallowed
            page_ack_d = page_ack_d | !pmsr_q;
            msr_ack_d  = msr_ack_d | pmsr_q;
        end
        if (mem_we && mem_waddr == R_LDR)
            ldr_d = mem_wdata;
        if (mem_we && mem_waddr == R_POL)
            pol_d = mem_wdata;
    end

    lic_regmem u_mem (
        .clk     (clk),
        .reset   (reset),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ext_q      <= 1'b0;
            pend_q     <= 1'b0;
            pmsr_q     <= 1'b0;
            idx_q      <= '0;
            page_ack_q <= 1'b0;
            page_err_q <= 1'b0;
            msr_ack_q  <= 1'b0;
            msr_err_q  <= 1'b0;
            ldr_q      <= ZERO32;
            pol_q      <= ZERO32;
        end
        else
        begin
            ext_q      <= ext_d;
            pend_q     <= pend_d;
            pmsr_q     <= pmsr_d;
            idx_q      <= idx_d;
            page_ack_q <= page_ack_d;
            page_err_q <= page_err_d;
            msr_ack_q  <= msr_ack_d;
            msr_err_q  <= msr_err_d;
            ldr_q      <= ldr_d;
            pol_q      <= pol_d;
        end
    end

    assign page_rdata_q = mem_rdata;
    assign msr_rdata_q  = mem_rdata;

    // ------------------------------------------------------------
    // destination matching
    // ------------------------------------------------------------
    logic [NCORES-1:0] hit;
    always_comb
    begin
        logic [31:0] id;
        id  = ZERO32;
        hit = '0;
        for (int i = 0; i < NCORES; i++)
        begin
            id = core_ids[32*i +: 32];
            if (!ext_q)
                // compat: 8-bit ids, flat logical mask
                hit[i] = irq_logical ? |(irq_dest[7:0] & ldr_q[31:24])
                       : (irq_dest[7:0] == BCAST_CMP || irq_dest[7:0] == id[7:0]);
            else if (irq_logical)
                // upper 24 dest bits must equal the LDR for a match; the low 8 bits are a mask
                hit[i] = irq_dest[31:16] == ldr_q[31:16]
                      && |(irq_dest[KEEP_W-1:0] & ldr_q[KEEP_W-1:0])
                      && irq_dest[HALF_W-1:KEEP_W] == ldr_q[HALF_W-1:KEEP_W];
            else
                hit[i] = irq_dest == BCAST_EXT
                      || (irq_dest[31:PHYS_KEEP] == '0
                          && irq_dest[PHYS_KEEP-1:0] == id[PHYS_KEEP-1:0]);
        end
    end

    // ------------------------------------------------------------
    // routing and delivery
    // ------------------------------------------------------------
    logic       r_found;
    logic [1:0] r_pick;
    lic_route u_route (
        .cand   (hit),
        .cstate (core_cstate),
        .perf   (pol_q[0]),
        .found  (r_found),
        .pick   (r_pick)
    );

    lic_state_t        st_q, st_d;
    logic [NCORES-1:0] hit_q, hit_d, dmask_d;
    logic [7:0]        vec_q, vec_d;
    logic              dlv_d, busy_d;
    always_comb
    begin
        st_d    = st_q;
        hit_d   = hit_q;
        vec_d   = vec_q;
        dlv_d   = 1'b0;
        dmask_d = '0;
        busy_d  = 1'b1;
        case (st_q)
            LIC_ST_IDLE:
            begin
                busy_d = 1'b0;
                if (irq_req)
                begin
                    hit_d  = hit;
                    vec_d  = irq_vector;
                    st_d   = (irq_redir && irq_logical) ? LIC_ST_PICK : LIC_ST_SEND;
                    busy_d = 1'b1;
                end
            end
            LIC_ST_PICK:
            begin
                // only one chosen core for redirectable logical requests
                hit_d = r_found ? NCORES'(1) << r_pick : '0;
                st_d  = LIC_ST_SEND;
            end
            LIC_ST_SEND:
            begin
                dlv_d   = |hit_q;
                dmask_d = hit_q;
                st_d    = LIC_ST_IDLE;
                busy_d  = 1'b0;
            end
            default:
            begin
                st_d = LIC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q             <= LIC_ST_IDLE;
            hit_q            <= '0;
            vec_q            <= '0;
            irq_busy_q       <= 1'b0;
            deliver_q        <= 1'b0;
            deliver_mask_q   <= '0;
            deliver_vector_q <= '0;
        end
        else
        begin
            st_q             <= st_d;
            hit_q            <= hit_d;
            vec_q            <= vec_d;
            irq_busy_q       <= busy_d;
            deliver_q        <= dlv_d;
            deliver_mask_q   <= dmask_d;
            deliver_vector_q <= vec_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    page_block_a: assert property (@(posedge clk) disable iff (reset)
        page_req && ext_q |=> page_ack_q && page_err_q)
        else $error("page access served in extended mode");
    page_serve_a: assert property (@(posedge clk) disable iff (reset)
        page_req && !ext_q |=> ##1 page_ack_q && !page_err_q)
        else $error("page access not answered");
    msr_serve_a: assert property (@(posedge clk) disable iff (reset)
        msr_req && ext_q && !page_req |=> ##1 msr_ack_q && !msr_err_q)
        else $error("msr access not answered");
    ext_sticky_a: assert property (@(posedge clk) disable iff (reset)
        ext_q |=> ext_q)
        else $error("extended mode dropped");
    send_after_a: assert property (@(posedge clk) disable iff (reset)
        irq_req && st_q == LIC_ST_IDLE && !irq_redir |=> ##1 (deliver_q == |hit_q))
        else $error("delivery timing wrong");
    one_target_a: assert property (@(posedge clk) disable iff (reset)
        st_q == LIC_ST_PICK ##2 deliver_q |-> $onehot(deliver_mask_q))
        else $error("redirected to several cores");
    msr_refuse_a: assert property (@(posedge clk) disable iff (reset)
        msr_req && !ext_q && !page_req |=> msr_ack_q && msr_err_q)
        else $error("msr access served in compat mode");
    busy_flag_a: assert property (@(posedge clk) disable iff (reset)
        irq_req && st_q == LIC_ST_IDLE |=> irq_busy_q)
        else $error("busy not raised on request");
    busy_state_a: assert property (@(posedge clk) disable iff (reset)
        irq_busy_q == (st_q != LIC_ST_IDLE))
        else $error("busy flag out of step");
    deliver_pulse_a: assert property (@(posedge clk) disable iff (reset)
        deliver_q |=> !deliver_q)
        else $error("delivery longer than one cycle");
    cover_page_c: cover property (@(posedge clk) page_ack_q && !page_err_q);
    cover_msr_c: cover property (@(posedge clk) msr_ack_q && !msr_err_q);
    cover_pick_c: cover property (@(posedge clk) st_q == LIC_ST_PICK && r_found);
    cover_refuse_c: cover property (@(posedge clk) page_ack_q && page_err_q);
    cover_multi_c: cover property (@(posedge clk) deliver_q && !$onehot(deliver_mask_q));
endmodule : lic_top

// file: verification/lic_core_model.sv
// far-side core model: reports idle state and id of every core
module lic_core_model
    import lic_pkg::*;
#(
    parameter logic [31:0] ID_STEP = 32'h0000_0100
)
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                set_en,
    input  wire logic [1:0]          set_core,
    input  wire lic_cstate_t         set_state,
    output logic      [2*NCORES-1:0] core_cstate,
    output logic      [NCORES*32-1:0] core_ids
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // idle states, held until the bench moves a core
    // ----------------------------------------------------------------
    logic [2*NCORES-1:0] cs_q;
    logic [2*NCORES-1:0] cs_d;
    always_comb
    begin
        cs_d = cs_q;
        if (set_en)
        begin
            cs_d[2*set_core +: 2] = set_state;
        end
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cs_q <= '0;
        end
        else
        begin
            cs_q <= cs_d;
        end
    end
    assign core_cstate = cs_q;
    // low byte of every id is zero, so only a wide compare tells cores apart
    for (genvar k = 0; k < NCORES; k++)
    begin : g_id
        assign core_ids[32*k +: 32] = ID_STEP * k;
    end
endmodule : lic_core_model

// file: verification/lic_top_bench.sv
// self-checking bench of the local interrupt unit
module lic_top_bench;
    import lic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic page_req = 1'b0, page_wr = 1'b0, msr_req = 1'b0, msr_wr = 1'b0;
    logic [PAGE_AW-1:0] page_addr = '0;
    logic [MSR_AW-1:0] msr_addr = '0;
    logic [DW-1:0] page_wdata = '0, msr_wdata = '0, page_rdata_q, msr_rdata_q;
    logic page_ack_q, page_err_q, msr_ack_q, msr_err_q;
    logic ext_mode_en = 1'b0, irq_req = 1'b0, irq_logical = 1'b0, irq_redir = 1'b0;
    logic [31:0] irq_dest = '0;
    logic [7:0] irq_vector = '0, deliver_vector_q;
    logic [2*NCORES-1:0] core_cstate;
    logic [NCORES*32-1:0] core_ids;
    logic irq_busy_q, deliver_q, set_en = 1'b0;
    logic [NCORES-1:0] deliver_mask_q;
    logic [1:0] set_core = '0;
    lic_cstate_t set_state = LIC_CS_C0;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rd;
    logic ak, er;
    always #4 clk = ~clk;
    lic_top u_dut (.clk(clk), .reset(reset), .page_req(page_req), .page_wr(page_wr),
        .page_addr(page_addr), .page_wdata(page_wdata), .page_ack_q(page_ack_q),
        .page_err_q(page_err_q), .page_rdata_q(page_rdata_q), .msr_req(msr_req),
        .msr_wr(msr_wr), .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack_q(msr_ack_q),
        .msr_err_q(msr_err_q), .msr_rdata_q(msr_rdata_q), .ext_mode_en(ext_mode_en),
        .irq_req(irq_req), .irq_logical(irq_logical), .irq_redir(irq_redir),
        .irq_dest(irq_dest), .irq_vector(irq_vector), .core_cstate(core_cstate),
        .core_ids(core_ids), .irq_busy_q(irq_busy_q), .deliver_q(deliver_q),
        .deliver_mask_q(deliver_mask_q), .deliver_vector_q(deliver_vector_q));
    lic_core_model u_cores (.clk(clk), .reset(reset), .set_en(set_en), .set_core(set_core),
        .set_state(set_state), .core_cstate(core_cstate), .core_ids(core_ids));
    // ----------------------------------------------------------------
    // shared drivers, all entered and left at a falling edge
    // ----------------------------------------------------------------
    task automatic acc(input logic m, input logic w, input logic [5:0] idx, input logic [31:0] d);
        page_req = !m; msr_req = m; page_wr = w; msr_wr = w;
        page_addr = {2'b00, idx, 4'h0}; msr_addr = {2'b00, idx};
        page_wdata = d; msr_wdata = d;
        @(negedge clk);
        page_req = 1'b0; msr_req = 1'b0;
        for (int n = 0; n < 4; n++)
        begin
            if ((page_ack_q | page_err_q | msr_ack_q | msr_err_q) === 1'b1) break;
            @(negedge clk);
        end
        rd = m ? msr_rdata_q : page_rdata_q;
        ak = m ? msr_ack_q : page_ack_q;
        er = m ? msr_err_q : page_err_q;
        @(negedge clk);
    endtask : acc
    task automatic irq(input logic lg, input logic rdr, input logic [31:0] dst,
                       input logic [7:0] vec, input logic [3:0] mask);
        irq_req = 1'b1; irq_logical = lg; irq_redir = rdr; irq_dest = dst; irq_vector = vec;
        @(negedge clk);
        `CHK(irq_busy_q, 1'b1)
        // second request while busy carries a bad vector; it must be ignored
        irq_vector = ~vec;
        @(negedge clk);
        irq_req = 1'b0;
        for (int n = 0; n < 6 && deliver_q !== 1'b1; n++) @(negedge clk);
        `CHK(deliver_q, 1'b1)
        `CHK(irq_busy_q, 1'b0)
        `CHK(deliver_mask_q, mask)
        `CHK(deliver_vector_q, vec)
        repeat (3) @(negedge clk);
        `CHK(deliver_q, 1'b0)
    endtask : irq
    task automatic set_cs(input logic [1:0] c, input lic_cstate_t s);
        set_en = 1'b1; set_core = c; set_state = s;
        @(negedge clk);
        set_en = 1'b0;
    endtask : set_cs
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_compat();
        acc(1'b0, 1'b1, R_TPR, 32'h1234_5678);
        `CHK(ak, 1'b1)
        `CHK(er, 1'b0)
        acc(1'b0, 1'b0, R_TPR, 32'h0000_0000);
        `CHK(rd, 32'h1234_5678)
        acc(1'b1, 1'b0, R_TPR, 32'h0000_0000);
        `CHK(er, 1'b1)
        // every core id has a zero low byte, so all four match here
        irq(1'b0, 1'b0, 32'h0000_0000, 8'h30, 4'b1111);
        $display("test compat done");
    endtask : t_compat
    task automatic t_ext();
        ext_mode_en = 1'b1;
        @(negedge clk);
        ext_mode_en = 1'b0;
        acc(1'b0, 1'b0, R_TPR, 32'h0000_0000);
        `CHK(er, 1'b1)
        `CHK(ak & ~er, 1'b0)
        acc(1'b1, 1'b0, R_TPR, 32'h0000_0000);
        `CHK(rd, 32'h1234_5678)
        `CHK(ak & ~er, 1'b1)
        acc(1'b1, 1'b1, R_LDR, 32'h0003_0005);
        acc(1'b1, 1'b0, R_LDR, 32'h0000_0000);
        `CHK(rd, 32'h0003_0005)
        $display("test ext done");
    endtask : t_ext
    task automatic t_phys();
        // only the bits above the low byte single out core 2
        irq(1'b0, 1'b0, 32'h0000_0200, 8'h41, 4'b0100);
        $display("test phys done");
    endtask : t_phys
    task automatic t_route();
        set_cs(2'd0, LIC_CS_DEEP);
        set_cs(2'd1, LIC_CS_C1);
        set_cs(2'd2, LIC_CS_C0);
        set_cs(2'd3, LIC_CS_DEEP);
        acc(1'b1, 1'b1, R_POL, 32'h0000_0000);
        irq(1'b1, 1'b1, 32'h0003_0004, 8'h52, 4'b0100);
        acc(1'b1, 1'b1, R_POL, 32'h0000_0001);
        irq(1'b1, 1'b1, 32'h0003_0004, 8'h63, 4'b0010);
        irq(1'b1, 1'b0, 32'h0003_0001, 8'h74, 4'b1111);
        $display("test route done");
    endtask : t_route
    // ----------------------------------------------------------------
    // verdict and run control
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial
    begin
        // budget is well above the fewer than one hundred cycles the tests need
        #(3000 * 8);
        num_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        `CHK(page_ack_q | msr_ack_q | deliver_q | irq_busy_q, 1'b0)
        t_compat();
        t_ext();
        t_phys();
        t_route();
        wrap_up();
    end
endmodule : lic_top_bench
